// *** tx_length_registers.sv ***
// Transmit-length register pair sizing the next transmit frame.
//
// Operation
// - High register holds byte count bits 11..4.
// - Low register upper nibble holds bits 3..0.
// - Reset or enable low clears both registers.
// - Transmit end of frame clears both registers.
// - Low register bits 3..1 count leftover bits.
// - Leftover count ignored without the partial flag.
// - Bit 0 flags a narrower last byte.
`timescale 1ns/1ps
module tx_length_registers
  import tx_length_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        chip_enable_in,
  input  wire logic [4:0]  reg_addr_in,
  input  wire logic        reg_write_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        tx_end_of_frame_in,
  output logic      [7:0]  reg_rdata_out,
  output logic      [11:0] byte_count_out,
  output logic      [2:0]  leftover_bits_out,
  output logic             partial_byte_out,
  output logic      [14:0] frame_bits_out
);

  // Enable pin synchroniser: three stages, a change counts when the last two agree.
  // The stages reset low, so the registers stay cleared until the pin is seen high.
  // A board that ties enable high still has to wait four edges before its first write.
  logic [2:0] enable_sync_reg;
  logic [2:0] enable_sync_next;
  logic       enable_level_reg;
  logic       enable_level_next;

  always_comb begin
    enable_sync_next  = {enable_sync_reg[1:0], chip_enable_in};
    enable_level_next = enable_level_reg;
    if (enable_sync_reg[2] == enable_sync_reg[1]) begin
      enable_level_next = enable_sync_reg[2];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enable_sync_reg  <= 3'h0;
      enable_level_reg <= 1'b0;
    end else begin
      enable_sync_reg  <= enable_sync_next;
      enable_level_reg <= enable_level_next;
    end
  end

  // The two stored registers; the host write port is assumed slow (about 2 MHz
  // serial) so one write per several clock cycles is the normal case.
  logic [7:0] count_high_reg;
  logic [7:0] count_high_next;
  logic [7:0] count_low_reg;
  logic [7:0] count_low_next;

  always_comb begin
    count_high_next = count_high_reg;
    count_low_next  = count_low_reg;
    if (reg_write_in && reg_addr_in == OFFSET_COUNT_HIGH) begin
      count_high_next = reg_wdata_in;
    end
    if (reg_write_in && reg_addr_in == OFFSET_COUNT_LOW) begin
      count_low_next = reg_wdata_in;
    end
    // end of frame clear. The frame end wins over a host write in the same
    // cycle, since the length it would set belongs to the frame just finished.
    if (tx_end_of_frame_in) begin
      count_high_next = RESET_LENGTH;
      count_low_next  = RESET_LENGTH;
    end
    if (!enable_level_reg) begin
      count_high_next = RESET_LENGTH;
      count_low_next  = RESET_LENGTH;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_high_reg <= RESET_LENGTH;
      count_low_reg  <= RESET_LENGTH;
    end else begin
      count_high_reg <= count_high_next;
      count_low_reg  <= count_low_next;
    end
  end

  // Decoded fields and read mux; unmapped addresses read as zero.
  // Reads have no strobe: the mux follows the address and never disturbs state.
  logic [11:0] byte_count;
  logic [2:0]  leftover_bits;
  logic        partial_byte;
  logic [2:0]  leftover_used;
  logic [14:0] frame_bits;
  logic [7:0]  rdata_next;

  always_comb begin
    byte_count    = {count_high_reg, count_low_reg[7:LOW_NIBBLE_POS]};
    leftover_bits = count_low_reg[LOW_NIBBLE_POS-1:LEFTOVER_POS];
    partial_byte  = count_low_reg[PARTIAL_FLAG_POS];
    leftover_used = partial_byte ? leftover_bits : 3'h0;
    frame_bits    = {byte_count, 3'h0} + {12'h000, leftover_used};
    rdata_next    = 8'h00;
    if (reg_addr_in == OFFSET_COUNT_HIGH) begin
      rdata_next = count_high_reg;
    end else if (reg_addr_in == OFFSET_COUNT_LOW) begin
      rdata_next = count_low_reg;
    end
  end

  // Outputs registered so the framer sees stable values one cycle after storage.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out     <= 8'h00;
      byte_count_out    <= 12'h000;
      leftover_bits_out <= 3'h0;
      partial_byte_out  <= 1'b0;
      frame_bits_out    <= 15'h0000;
    end else begin
      reg_rdata_out     <= rdata_next;
      byte_count_out    <= byte_count;
      leftover_bits_out <= leftover_used;
      partial_byte_out  <= partial_byte;
      frame_bits_out    <= frame_bits;
    end
  end

  // Checks on the register behaviour. The write sequences exclude both clearing causes,
  // so a failure there points at the storage path and not at a clear.
  sequence s_eof;
    tx_end_of_frame_in;
  endsequence

  sequence s_high_write;
    reg_write_in && reg_addr_in == OFFSET_COUNT_HIGH && !tx_end_of_frame_in && enable_level_reg;
  endsequence

  sequence s_low_write;
    reg_write_in && reg_addr_in == OFFSET_COUNT_LOW && !tx_end_of_frame_in && enable_level_reg;
  endsequence

  // The enable level may only move once the last two stages agree.
  sequence s_enable_unsettled;
    enable_sync_reg[2] != enable_sync_reg[1];
  endsequence

  a_eof_clears_all: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_eof |=> (count_high_reg == RESET_LENGTH && count_low_reg == RESET_LENGTH))
    else $error("End of frame did not clear length registers.");

  // The framer sees the cleared size one edge after the registers clear.
  a_eof_outputs_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_eof |=> ##1 (byte_count_out == 12'h000 && frame_bits_out == 15'h0000 && !partial_byte_out))
    else $error("End of frame did not clear the frame size outputs.");

  a_enable_low_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !enable_level_reg |=> (count_high_reg == RESET_LENGTH && count_low_reg == RESET_LENGTH))
    else $error("Enable low did not clear length registers.");

  // A single stage disagreeing must not move the level; an agreed pair must.
  a_enable_filter: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_enable_unsettled |=> $stable(enable_level_reg))
    else $error("Enable level moved before the sync stages agreed.");

  a_enable_follows: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (enable_sync_reg[2] == enable_sync_reg[1]) |=> (enable_level_reg == $past(enable_sync_reg[2])))
    else $error("Enable level did not follow the agreed sync stages.");

  a_high_write_stores: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_high_write |=> ##1 (byte_count_out[11:4] == $past(reg_wdata_in, 2)))
    else $error("High byte count write not reflected.");

  a_low_write_stores: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_low_write |=> ##1 (byte_count_out[3:0] == $past(reg_wdata_in[7:4], 2)))
    else $error("Low byte count nibble not reflected.");

  // Read data is registered, so it shows the stored value one edge after the address.
  a_high_readback: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (reg_addr_in == OFFSET_COUNT_HIGH) |=> (reg_rdata_out == $past(count_high_reg)))
    else $error("High length register read back wrongly.");

  a_low_readback: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (reg_addr_in == OFFSET_COUNT_LOW) |=> (reg_rdata_out == $past(count_low_reg)))
    else $error("Low length register read back wrongly.");

  a_unmapped_reads_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (reg_addr_in != OFFSET_COUNT_HIGH && reg_addr_in != OFFSET_COUNT_LOW) |=> (reg_rdata_out == 8'h00))
    else $error("Unmapped address did not read as zero.");

  // Without a cause the pair must hold; a stray clear would shorten the next frame.
  a_length_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!reg_write_in && !tx_end_of_frame_in && enable_level_reg)
      |=> ($stable(count_high_reg) && $stable(count_low_reg)))
    else $error("Length registers changed without a write or a clear.");

  a_leftover_field_map: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    partial_byte |=> (leftover_bits_out == $past(count_low_reg[3:1])))
    else $error("Leftover field mapped wrongly.");

  a_leftover_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !count_low_reg[0] |=> (leftover_bits_out == 3'h0))
    else $error("Leftover count used without partial flag.");

  a_partial_flag_map: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> (partial_byte_out == $past(count_low_reg[0])))
    else $error("Partial flag output wrong.");

  a_frame_bits_sum: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    frame_bits_out == 15'({byte_count_out, 3'h0}) + 15'(leftover_bits_out))
    else $error("Frame bit total wrong.");

endmodule : tx_length_registers

// *** tx_length_pkg.sv ***
// Package with register offsets, field positions and reset values of the transmit-length registers.
package tx_length_pkg;
  localparam logic [4:0] ADDR_WIDTH_BITS   = 5'h05;
  localparam logic [4:0] OFFSET_COUNT_HIGH = 5'h1D;
  localparam logic [4:0] OFFSET_COUNT_LOW  = 5'h1E;
  localparam logic [7:0] RESET_LENGTH      = 8'h00;
  localparam int         LOW_NIBBLE_POS    = 4;
  localparam int         LEFTOVER_POS      = 1;
  localparam int         PARTIAL_FLAG_POS  = 0;
  localparam int         BYTE_COUNT_WIDTH  = 12;
  localparam int         FRAME_BITS_WIDTH  = 15;
  localparam int         HOST_CLOCK_HZ     = 2000000;
endpackage : tx_length_pkg

// *** host_model.sv ***
// Host model that drives the register port of the length registers.
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_in,
  output logic      [4:0] reg_addr_out,
  output logic            reg_write_out,
  output logic      [7:0] reg_wdata_out
);
  initial begin
    reg_addr_out  = 5'h00;
    reg_write_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // host pace free.
  // One strobe per write; released data is inverted so it is never mistaken for held data.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_out  <= a;
    reg_write_out <= 1'b1;
    reg_wdata_out <= d;
    @(posedge clk_in);
    reg_write_out <= 1'b0;
    reg_wdata_out <= ~d;
  endtask : wr
  // Read data appears one edge after the address, so the task waits one edge.
  task automatic rd(input logic [4:0] a);
    @(posedge clk_in);
    reg_addr_out <= a;
    @(posedge clk_in);
    #1;
  endtask : rd
endmodule : host_model

// *** testbench.sv ***
// Self-checking bench for the transmit-length registers.
`timescale 1ns/1ps
module testbench;
  import tx_length_pkg::*;
  logic        clk_in, rst_n_in, chip_enable_in, tx_end_of_frame_in, reg_write_in;
  logic [4:0]  reg_addr_in;
  logic [7:0]  reg_wdata_in, reg_rdata_out, hi, lo;
  logic [11:0] byte_count_out;
  logic [2:0]  leftover_bits_out;
  logic        partial_byte_out;
  logic [14:0] frame_bits_out;
  int          num_errors = 0, cmp_count = 0, cycles = 0;
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  host_model host (.clk_in(clk_in), .reg_addr_out(reg_addr_in), .reg_write_out(reg_write_in),
                   .reg_wdata_out(reg_wdata_in));
  tx_length_registers dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .chip_enable_in(chip_enable_in),
    .reg_addr_in(reg_addr_in), .reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in),
    .tx_end_of_frame_in(tx_end_of_frame_in), .reg_rdata_out(reg_rdata_out),
    .byte_count_out(byte_count_out), .leftover_bits_out(leftover_bits_out),
    .partial_byte_out(partial_byte_out), .frame_bits_out(frame_bits_out));
  task automatic chk(input string n, input logic [14:0] seen, input logic [14:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // Leftover bits count only when the partial flag is set.
  function automatic logic [2:0] left_exp(input logic [7:0] l);
    return l[0] ? l[3:1] : 3'h0;
  endfunction : left_exp
  task automatic test_done();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // A hang is cut short well past the few hundred cycles the run needs.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 3000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h9886));
    rst_n_in = 1'b0;
    chip_enable_in = 1'b0;
    tx_end_of_frame_in = 1'b0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chip_enable_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    chk("frame_bits", frame_bits_out, 15'h0000);
    // Corner cases first: all ones, then leftover bits without the flag.
    for (int i = 0; i < 20; i++) begin
      hi = (i == 0) ? 8'hFF : 8'($urandom);
      lo = (i == 0) ? 8'hFF : (i == 1) ? 8'h0E : 8'($urandom);
      host.wr(OFFSET_COUNT_HIGH, hi);
      host.wr(OFFSET_COUNT_LOW, lo);
      host.wr(5'h1C, 8'($urandom));
      // Sample after the edge, once the unmapped address has been registered.
      #1;
      chk("byte_count", 15'(byte_count_out), 15'({hi, lo[7:4]}));
      chk("leftover", 15'(leftover_bits_out), 15'(left_exp(lo)));
      chk("partial", 15'(partial_byte_out), 15'(lo[0]));
      chk("frame_bits", frame_bits_out, 15'({hi, lo[7:4]}) * 15'h0008 + 15'(left_exp(lo)));
      chk("rdata_unmapped", 15'(reg_rdata_out), 15'h0000);
      host.rd(OFFSET_COUNT_HIGH);
      chk("rdata_high", 15'(reg_rdata_out), 15'(hi));
      host.rd(OFFSET_COUNT_LOW);
      chk("rdata_low", 15'(reg_rdata_out), 15'(lo));
      // Rotate the clearing causes: end of frame racing a write, enable low, reset.
      @(posedge clk_in);
      if (i % 3 == 0) begin
        fork
          host.wr(OFFSET_COUNT_HIGH, 8'h5A);
          begin
            @(posedge clk_in);
            tx_end_of_frame_in <= 1'b1;
            @(posedge clk_in);
            tx_end_of_frame_in <= 1'b0;
          end
        join
      end else if (i % 3 == 1) begin
        chip_enable_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        chip_enable_in <= 1'b1;
        repeat (5) @(posedge clk_in);
      end else begin
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (5) @(posedge clk_in);
      end
      host.rd(OFFSET_COUNT_LOW);
      chk("cleared_low", 15'(reg_rdata_out), 15'(RESET_LENGTH));
      chk("cleared_frame", frame_bits_out, 15'h0000);
      host.rd(OFFSET_COUNT_HIGH);
      chk("cleared_high", 15'(reg_rdata_out), 15'(RESET_LENGTH));
    end
    test_done();
  end
endmodule : testbench
